// ### pmb_defs.svh
// constants for the limit and sequencing command bank
`ifndef PMB_DEFS_SVH
`define PMB_DEFS_SVH

// command codes
`define PMB_CMD_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR      8'h20
`define PMB_CMD_OT_FLT_LIM     8'h4f
`define PMB_CMD_OT_FLT_ACT     8'h50
`define PMB_CMD_OT_WRN_LIM     8'h51
`define PMB_CMD_UT_WRN_LIM     8'h52
`define PMB_CMD_UT_FLT_LIM     8'h53
`define PMB_CMD_UT_FLT_ACT     8'h54
`define PMB_CMD_VIN_OV_FLT_LIM 8'h55
`define PMB_CMD_VIN_OV_FLT_ACT 8'h56
`define PMB_CMD_VIN_OV_WRN_LIM 8'h57
`define PMB_CMD_VIN_UV_WRN_LIM 8'h58
`define PMB_CMD_VIN_UV_FLT_LIM 8'h59
`define PMB_CMD_VIN_UV_FLT_ACT 8'h5a
`define PMB_CMD_PGOOD_THR      8'h5e
`define PMB_CMD_TON_DLY        8'h60
`define PMB_CMD_TON_RAMP       8'h61
`define PMB_CMD_TOFF_DLY       8'h64

// storage slot of each entry
`define PMB_IDX_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR      5'h00
`define PMB_IDX_OT_FLT_LIM     5'h01
`define PMB_IDX_OT_FLT_ACT     5'h02
`define PMB_IDX_OT_WRN_LIM     5'h03
`define PMB_IDX_UT_WRN_LIM     5'h04
`define PMB_IDX_UT_FLT_LIM     5'h05
`define PMB_IDX_UT_FLT_ACT     5'h06
`define PMB_IDX_VIN_OV_FLT_LIM 5'h07
`define PMB_IDX_VIN_OV_FLT_ACT 5'h08
`define PMB_IDX_VIN_OV_WRN_LIM 5'h09
`define PMB_IDX_VIN_UV_WRN_LIM 5'h0a
`define PMB_IDX_VIN_UV_FLT_LIM 5'h0b
`define PMB_IDX_VIN_UV_FLT_ACT 5'h0c
`define PMB_IDX_PGOOD_THR      5'h0d
`define PMB_IDX_TON_DLY        5'h0e
`define PMB_IDX_TON_RAMP       5'h0f
`define PMB_IDX_TOFF_DLY       5'h10
`define PMB_NUM_ENTRIES        17

// reset values
`define PMB_RST_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR      16'h0013
`define PMB_RST_OT_FLT_LIM     16'hebe8
`define PMB_RST_FLT_ACT        16'h0080
`define PMB_RST_OT_WRN_LIM     16'heb70
`define PMB_RST_UT_WRN_LIM     16'he4e0
`define PMB_RST_UT_FLT_LIM     16'he490
`define PMB_RST_VIN_OV_FLT_LIM 16'hd3a0
`define PMB_RST_VIN_OV_WRN_LIM 16'hd34d
`define PMB_RST_VIN_UV_WRN_LIM 16'hca30
`define PMB_RST_VIN_UV_FLT_LIM 16'hca00
`define PMB_RST_VIN_UV_FLT_ACT 16'h0000
`define PMB_RST_TON_DLY        16'hca80
`define PMB_RST_TON_RAMP       16'hd280
`define PMB_RST_TOFF_DLY       16'hca80

// power-good default is nine tenths of the strapped output voltage
`define PMB_PGOOD_NUM          20'h00009
`define PMB_PGOOD_DEN          20'h0000a

// read byte returned for an unknown code or the second byte of a one-byte entry
`define PMB_RD_FILL            8'hff

// sequencing time base: one tick is a sixteenth of a millisecond
`define PMB_CLK_PERIOD_NS      50
`define PMB_TICK_NS            62500
`define PMB_TICK_CYCLES        (`PMB_TICK_NS / `PMB_CLK_PERIOD_NS)
`define PMB_TICKS_PER_MS_LOG2  4

`endif

// ### pmb_pkg.sv
// types shared by the limit and sequencing command bank
package pmb_pkg;

    typedef enum logic [1:0] {
        PMB_P_IDLE = 2'b00,
        PMB_P_CMD  = 2'b01,
        PMB_P_DATA = 2'b10,
        PMB_P_READ = 2'b11
    } pmb_prot_state_t;

    typedef enum logic [2:0] {
        PMB_S_OFF      = 3'b000,
        PMB_S_ON_DLY   = 3'b001,
        PMB_S_RISING   = 3'b010,
        PMB_S_ON       = 3'b011,
        PMB_S_OFF_DLY  = 3'b100
    } pmb_seq_state_t;

endpackage

// ### pmb_cfg_mem.sv
// configuration storage of the command bank with a registered read port
`timescale 1ns/10ps
`default_nettype none
`include "pmb_defs.svh"

module pmb_cfg_mem #(
    parameter int N = `PMB_NUM_ENTRIES,
    parameter int W = 16
) (
    // clock and reset
    input  wire logic           i_ref_clk,
    input  wire logic           i_sys_rst,
    // write port
    input  wire logic           i_wr_en,
    input  wire logic [4:0]     i_wr_idx,
    input  wire logic [W-1:0]   i_wr_data,
    // read port
    input  wire logic [4:0]     i_rd_idx,
    output logic      [W-1:0]   o_rd_data,
    // every entry, for the block's own logic
    output logic      [N*W-1:0] o_entries
);

    // reset value of each slot
    function automatic logic [W-1:0] rst_val(input int idx);
        logic [W-1:0] v;
        v = `PMB_RST_FLT_ACT;
        case (idx)
            0:  v = `PMB_RST_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR;
            1:  v = `PMB_RST_OT_FLT_LIM;
            3:  v = `PMB_RST_OT_WRN_LIM;
            4:  v = `PMB_RST_UT_WRN_LIM;
            5:  v = `PMB_RST_UT_FLT_LIM;
            7:  v = `PMB_RST_VIN_OV_FLT_LIM;
            9:  v = `PMB_RST_VIN_OV_WRN_LIM;
            10: v = `PMB_RST_VIN_UV_WRN_LIM;
            11: v = `PMB_RST_VIN_UV_FLT_LIM;
            12: v = `PMB_RST_VIN_UV_FLT_ACT;
            13: v = '0;
            14: v = `PMB_RST_TON_DLY;
            15: v = `PMB_RST_TON_RAMP;
            16: v = `PMB_RST_TOFF_DLY;
            default: v = `PMB_RST_FLT_ACT;
        endcase
        return v;
    endfunction

    logic [W-1:0] rd_nxt;

    // one storage word per slot
    for (genvar g = 0; g < N; g++) begin : g_slot
        logic [W-1:0] word_r;
        logic [W-1:0] word_nxt;
        always_comb begin
            word_nxt = word_r;
            if (i_wr_en && (i_wr_idx == 5'(g))) begin
                word_nxt = i_wr_data;
            end
        end
        always_ff @(posedge i_ref_clk) begin
            if (i_sys_rst) begin
                word_r <= rst_val(g);
            end else begin
                word_r <= word_nxt;
            end
        end
        assign o_entries[g*W +: W] = word_r;
    end

    // registered read mux
    always_comb begin
        rd_nxt = '0;
        if (int'(i_rd_idx) < N) begin
            rd_nxt = o_entries[i_rd_idx*W +: W];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= rd_nxt;
        end
    end

endmodule
`default_nettype wire

// ### pmb_seq_timer.sv
// turn-on delay, rise and turn-off delay sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pmb_defs.svh"

module pmb_seq_timer #(
    parameter int TICK_CYCLES = `PMB_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // enable request and timing words
    input  wire logic        i_enable,
    input  wire logic [15:0] i_turn_on_delay,
    input  wire logic [15:0] i_turn_on_ramp_time,
    input  wire logic [15:0] i_turn_off_delay,
    // sequencing state
    output logic             o_output_on,
    output logic             o_ramp_up,
    output logic             o_off_pending
);

    // eleven-bit linear word to a count of ticks; negative mantissa gives zero
    function automatic logic [31:0] lin_to_ticks(input logic [15:0] w);
        logic signed [4:0] expo;
        logic        [31:0] base;
        expo = signed'(w[15:11]);
        base = {17'h0, w[9:0], 5'h0} >> 1;
        if (w[10]) begin
            return '0;
        end else if (expo >= 0) begin
            return base << expo;
        end else begin
            return base >> (-expo);
        end
    endfunction

    pmb_pkg::pmb_seq_state_t state_r, state_nxt;
    logic [15:0] pre_r, pre_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic        tick;
    logic [31:0] target;

    // target of the current phase
    always_comb begin
        tick = (pre_r == 16'(TICK_CYCLES - 1));
        unique case (state_r)
            pmb_pkg::PMB_S_ON_DLY:  target = lin_to_ticks(i_turn_on_delay);
            pmb_pkg::PMB_S_RISING:  target = lin_to_ticks(i_turn_on_ramp_time);
            pmb_pkg::PMB_S_OFF_DLY: target = lin_to_ticks(i_turn_off_delay);
            default:                target = '0;
        endcase
    end

    // phase sequencing; the counters restart on every phase change
    always_comb begin
        state_nxt = state_r;
        pre_nxt   = tick ? 16'h0 : pre_r + 16'h1;
        cnt_nxt   = tick ? cnt_r + 32'h1 : cnt_r;
        unique case (state_r)
            pmb_pkg::PMB_S_OFF: begin
                if (i_enable) state_nxt = pmb_pkg::PMB_S_ON_DLY;
            end
            pmb_pkg::PMB_S_ON_DLY: begin
                if (!i_enable) state_nxt = pmb_pkg::PMB_S_OFF;
                else if (cnt_r >= target) state_nxt = pmb_pkg::PMB_S_RISING;
            end
            pmb_pkg::PMB_S_RISING: begin
                if (!i_enable) state_nxt = pmb_pkg::PMB_S_OFF_DLY;
                else if (cnt_r >= target) state_nxt = pmb_pkg::PMB_S_ON;
            end
            pmb_pkg::PMB_S_ON: begin
                if (!i_enable) state_nxt = pmb_pkg::PMB_S_OFF_DLY;
            end
            pmb_pkg::PMB_S_OFF_DLY: begin
                if (i_enable) state_nxt = pmb_pkg::PMB_S_ON;
                else if (cnt_r >= target) state_nxt = pmb_pkg::PMB_S_OFF;
            end
            default: state_nxt = pmb_pkg::PMB_S_OFF;
        endcase
        if (state_nxt != state_r) begin
            pre_nxt = 16'h0;
            cnt_nxt = 32'h0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_r       <= pmb_pkg::PMB_S_OFF;
            pre_r         <= 16'h0;
            cnt_r         <= 32'h0;
            o_output_on   <= 1'b0;
            o_ramp_up     <= 1'b0;
            o_off_pending <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            pre_r         <= pre_nxt;
            cnt_r         <= cnt_nxt;
            o_output_on   <= (state_nxt == pmb_pkg::PMB_S_RISING) || (state_nxt == pmb_pkg::PMB_S_ON)
                             || (state_nxt == pmb_pkg::PMB_S_OFF_DLY);
            o_ramp_up     <= (state_nxt == pmb_pkg::PMB_S_RISING);
            o_off_pending <= (state_nxt == pmb_pkg::PMB_S_OFF_DLY);
        end
    end

endmodule
`default_nettype wire

// ### pmb_cmd_bank.sv
// command-addressed limit and sequencing bank behind the serial bus byte engine
`timescale 1ns/10ps
`default_nettype none
`include "pmb_defs.svh"

module pmb_cmd_bank #(
    parameter int TICK_CYCLES = `PMB_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // byte engine of the serial bus
    input  wire logic        i_bus_start,
    input  wire logic        i_bus_stop,
    input  wire logic        i_bus_byte_valid,
    input  wire logic [7:0]  i_bus_byte,
    input  wire logic        i_bus_rd_req,
    output logic             o_bus_ack,
    output logic             o_bus_nack,
    output logic             o_bus_rd_valid,
    output logic [7:0]       o_bus_rd_byte,
    // strap and enable
    input  wire logic [15:0] i_vout_strap,
    input  wire logic        i_enable,
    // limits and actions for the protection logic
    output logic [15:0]      o_overtemp_fault_limit,
    output logic [7:0]       o_overtemp_fault_action,
    output logic [15:0]      o_overtemp_warning_limit,
    output logic [15:0]      o_undertemp_warning_limit,
    output logic [15:0]      o_undertemp_fault_limit,
    output logic [7:0]       o_undertemp_fault_action,
    output logic [15:0]      o_input_overvolt_fault_limit,
    output logic [7:0]       o_input_overvolt_fault_action,
    output logic [15:0]      o_input_overvolt_warning_limit,
    output logic [15:0]      o_input_undervolt_warning_limit,
    output logic [15:0]      o_input_undervolt_fault_limit,
    output logic [7:0]       o_input_undervolt_fault_action,
    output logic [15:0]      o_power_good_threshold,
    // sequencing state
    output logic             o_output_on,
    output logic             o_ramp_up,
    output logic             o_off_pending
);

    localparam int NE = `PMB_NUM_ENTRIES;

    pmb_pkg::pmb_prot_state_t st_r, st_nxt;
    logic [4:0]    idx_r, idx_nxt;
    logic          hit_r, hit_nxt;
    logic [7:0]    lo_r, lo_nxt;
    logic [7:0]    hi_r, hi_nxt;
    logic [1:0]    cnt_r, cnt_nxt;
    logic          over_r, over_nxt;
    logic          rdph_r, rdph_nxt;
    logic          rdgo_r, rdgo_nxt;
    logic          pgld_r, pgld_nxt;
    logic          ack_nxt, nack_nxt;
    logic          rdv_nxt;
    logic [7:0]    rdb_nxt;
    logic [4:0]    dec_idx;
    logic          dec_hit;
    logic [1:0]    need;
    logic          ro;
    logic          wr_en;
    logic [4:0]    wr_idx;
    logic [15:0]   wr_data;
    logic [15:0]   mem_rd;
    logic [NE*16-1:0] ent;
    logic [19:0]   pg_prod;

    // command code to storage slot
    always_comb begin
        dec_hit = 1'b1;
        dec_idx = `PMB_IDX_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR;
        unique case (i_bus_byte)
            `PMB_CMD_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR:      dec_idx = `PMB_IDX_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR;
            `PMB_CMD_OT_FLT_LIM:     dec_idx = `PMB_IDX_OT_FLT_LIM;
            `PMB_CMD_OT_FLT_ACT:     dec_idx = `PMB_IDX_OT_FLT_ACT;
            `PMB_CMD_OT_WRN_LIM:     dec_idx = `PMB_IDX_OT_WRN_LIM;
            `PMB_CMD_UT_WRN_LIM:     dec_idx = `PMB_IDX_UT_WRN_LIM;
            `PMB_CMD_UT_FLT_LIM:     dec_idx = `PMB_IDX_UT_FLT_LIM;
            `PMB_CMD_UT_FLT_ACT:     dec_idx = `PMB_IDX_UT_FLT_ACT;
            `PMB_CMD_VIN_OV_FLT_LIM: dec_idx = `PMB_IDX_VIN_OV_FLT_LIM;
            `PMB_CMD_VIN_OV_FLT_ACT: dec_idx = `PMB_IDX_VIN_OV_FLT_ACT;
            `PMB_CMD_VIN_OV_WRN_LIM: dec_idx = `PMB_IDX_VIN_OV_WRN_LIM;
            `PMB_CMD_VIN_UV_WRN_LIM: dec_idx = `PMB_IDX_VIN_UV_WRN_LIM;
            `PMB_CMD_VIN_UV_FLT_LIM: dec_idx = `PMB_IDX_VIN_UV_FLT_LIM;
            `PMB_CMD_VIN_UV_FLT_ACT: dec_idx = `PMB_IDX_VIN_UV_FLT_ACT;
            `PMB_CMD_PGOOD_THR:      dec_idx = `PMB_IDX_PGOOD_THR;
            `PMB_CMD_TON_DLY:        dec_idx = `PMB_IDX_TON_DLY;
            `PMB_CMD_TON_RAMP:       dec_idx = `PMB_IDX_TON_RAMP;
            `PMB_CMD_TOFF_DLY:       dec_idx = `PMB_IDX_TOFF_DLY;
            default:                 dec_hit = 1'b0;
        endcase
    end

    // data bytes each slot takes, and the read-only format byte
    always_comb begin
        unique case (idx_r)
            `PMB_IDX_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR, `PMB_IDX_OT_FLT_ACT, `PMB_IDX_UT_FLT_ACT,
            `PMB_IDX_VIN_OV_FLT_ACT, `PMB_IDX_VIN_UV_FLT_ACT: need = 2'd1;
            default: need = 2'd2;
        endcase
        ro = (idx_r == `PMB_IDX_OUTPUT_VOLTAGE_FORMAT_DESCRIPTOR);
    end

    // strapped power-good default, loaded in the first cycle after reset
    always_comb begin
        pg_prod = ({4'h0, i_vout_strap} * `PMB_PGOOD_NUM) / `PMB_PGOOD_DEN;
    end

    // transaction engine: command byte, data bytes, read bytes, commit at stop
    always_comb begin
        st_nxt   = st_r;
        idx_nxt  = idx_r;
        hit_nxt  = hit_r;
        lo_nxt   = lo_r;
        hi_nxt   = hi_r;
        cnt_nxt  = cnt_r;
        over_nxt = over_r;
        rdph_nxt = rdph_r;
        rdgo_nxt = 1'b0;
        pgld_nxt = 1'b0;
        ack_nxt  = 1'b0;
        nack_nxt = 1'b0;
        rdv_nxt  = 1'b0;
        rdb_nxt  = o_bus_rd_byte;
        wr_en    = 1'b0;
        wr_idx   = idx_r;
        wr_data  = {hi_r, lo_r};
        if (i_bus_start) begin
            if (st_r == pmb_pkg::PMB_P_IDLE) begin
                st_nxt  = pmb_pkg::PMB_P_CMD;
                cnt_nxt = 2'd0;
                over_nxt = 1'b0;
            end
            rdph_nxt = 1'b0;
        end else if (i_bus_stop) begin
            if (st_r == pmb_pkg::PMB_P_DATA && hit_r && !ro && !over_r && cnt_r == need) begin
                wr_en = 1'b1;
                if (need == 2'd1) wr_data = {8'h00, lo_r};
            end
            st_nxt = pmb_pkg::PMB_P_IDLE;
        end else if (i_bus_byte_valid) begin
            if (st_r == pmb_pkg::PMB_P_CMD) begin
                idx_nxt  = dec_idx;
                hit_nxt  = dec_hit;
                ack_nxt  = dec_hit;
                nack_nxt = !dec_hit;
                st_nxt   = pmb_pkg::PMB_P_DATA;
            end else if (st_r == pmb_pkg::PMB_P_DATA && hit_r && !ro && !over_r && cnt_r < need) begin
                if (cnt_r == 2'd0) lo_nxt = i_bus_byte;  // low byte first
                else hi_nxt = i_bus_byte;
                cnt_nxt = cnt_r + 2'd1;
                ack_nxt = 1'b1;
            end else begin
                over_nxt = 1'b1;
                nack_nxt = 1'b1;
            end
        end else if (i_bus_rd_req && (st_r == pmb_pkg::PMB_P_DATA || st_r == pmb_pkg::PMB_P_READ)) begin
            st_nxt   = pmb_pkg::PMB_P_READ;
            rdgo_nxt = 1'b1;
        end
        // answer a read request one cycle later from the registered read port
        if (rdgo_r) begin
            rdv_nxt = 1'b1;
            if (!hit_r || (rdph_r && need == 2'd1)) rdb_nxt = `PMB_RD_FILL;
            else if (rdph_r) rdb_nxt = mem_rd[15:8];
            else rdb_nxt = mem_rd[7:0];
            rdph_nxt = 1'b1;
        end
        // strapped default takes the write port ahead of the bus
        if (pgld_r) begin
            wr_en   = 1'b1;
            wr_idx  = `PMB_IDX_PGOOD_THR;
            wr_data = pg_prod[15:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_r           <= pmb_pkg::PMB_P_IDLE;
            idx_r          <= 5'h00;
            hit_r          <= 1'b0;
            lo_r           <= 8'h00;
            hi_r           <= 8'h00;
            cnt_r          <= 2'd0;
            over_r         <= 1'b0;
            rdph_r         <= 1'b0;
            rdgo_r         <= 1'b0;
            pgld_r         <= 1'b1;
            o_bus_ack      <= 1'b0;
            o_bus_nack     <= 1'b0;
            o_bus_rd_valid <= 1'b0;
            o_bus_rd_byte  <= 8'h00;
        end else begin
            st_r           <= st_nxt;
            idx_r          <= idx_nxt;
            hit_r          <= hit_nxt;
            lo_r           <= lo_nxt;
            hi_r           <= hi_nxt;
            cnt_r          <= cnt_nxt;
            over_r         <= over_nxt;
            rdph_r         <= rdph_nxt;
            rdgo_r         <= rdgo_nxt;
            pgld_r         <= pgld_nxt;
            o_bus_ack      <= ack_nxt;
            o_bus_nack     <= nack_nxt;
            o_bus_rd_valid <= rdv_nxt;
            o_bus_rd_byte  <= rdb_nxt;
        end
    end

    // entry storage
    pmb_cfg_mem #(
        .N (NE),
        .W (16)
    ) u_mem (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_en),
        .i_wr_idx  (wr_idx),
        .i_wr_data (wr_data),
        .i_rd_idx  (idx_r),
        .o_rd_data (mem_rd),
        .o_entries (ent)
    );

    // power sequencing from the three timing words
    pmb_seq_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_seq (
        .i_ref_clk           (i_ref_clk),
        .i_sys_rst           (i_sys_rst),
        .i_enable            (i_enable),
        .i_turn_on_delay     (ent[`PMB_IDX_TON_DLY*16 +: 16]),
        .i_turn_on_ramp_time (ent[`PMB_IDX_TON_RAMP*16 +: 16]),
        .i_turn_off_delay    (ent[`PMB_IDX_TOFF_DLY*16 +: 16]),
        .o_output_on         (o_output_on),
        .o_ramp_up           (o_ramp_up),
        .o_off_pending       (o_off_pending)
    );

    // stored entries straight out to the protection logic
    assign o_overtemp_fault_limit          = ent[`PMB_IDX_OT_FLT_LIM*16 +: 16];
    assign o_overtemp_fault_action         = ent[`PMB_IDX_OT_FLT_ACT*16 +: 8];
    assign o_overtemp_warning_limit        = ent[`PMB_IDX_OT_WRN_LIM*16 +: 16];
    assign o_undertemp_warning_limit       = ent[`PMB_IDX_UT_WRN_LIM*16 +: 16];
    assign o_undertemp_fault_limit         = ent[`PMB_IDX_UT_FLT_LIM*16 +: 16];
    assign o_undertemp_fault_action        = ent[`PMB_IDX_UT_FLT_ACT*16 +: 8];
    assign o_input_overvolt_fault_limit    = ent[`PMB_IDX_VIN_OV_FLT_LIM*16 +: 16];
    assign o_input_overvolt_fault_action   = ent[`PMB_IDX_VIN_OV_FLT_ACT*16 +: 8];
    assign o_input_overvolt_warning_limit  = ent[`PMB_IDX_VIN_OV_WRN_LIM*16 +: 16];
    assign o_input_undervolt_warning_limit = ent[`PMB_IDX_VIN_UV_WRN_LIM*16 +: 16];
    assign o_input_undervolt_fault_limit   = ent[`PMB_IDX_VIN_UV_FLT_LIM*16 +: 16];
    assign o_input_undervolt_fault_action  = ent[`PMB_IDX_VIN_UV_FLT_ACT*16 +: 8];
    assign o_power_good_threshold          = ent[`PMB_IDX_PGOOD_THR*16 +: 16];

endmodule
`default_nettype wire

// ### pmb_cmd_bank_checker.sv
// port assertions for the command bank
`timescale 1ns/10ps
`default_nettype none
module pmb_cmd_bank_checker (
    // watched ports
    input wire logic       i_ref_clk, i_sys_rst, i_bus_byte_valid, i_bus_rd_req, i_enable,
    input wire logic       o_bus_ack, o_bus_nack, o_bus_rd_valid, o_output_on, o_ramp_up, o_off_pending,
    input wire logic [7:0] o_overtemp_fault_action
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // byte answers, read answers and the fault action default after reset
    property p_ack; i_bus_byte_valid |=> o_bus_ack ^ o_bus_nack; endproperty
    a_ack: assert property (p_ack) else $error("byte not answered");
    property p_idle; !i_bus_byte_valid |=> !(o_bus_ack || o_bus_nack); endproperty
    a_idle: assert property (p_idle) else $error("answer without byte");
    property p_rdv; i_bus_rd_req |-> ##2 o_bus_rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("read byte late");
    property p_rst; disable iff (1'b0) i_sys_rst |=> o_overtemp_fault_action == 8'h80; endproperty
    a_rst: assert property (p_rst) else $error("fault action default wrong");
    // sequencer phases
    property p_ramp; o_ramp_up |-> o_output_on; endproperty
    a_ramp: assert property (p_ramp) else $error("ramp while off");
    property p_offp; o_off_pending |-> o_output_on && !o_ramp_up; endproperty
    a_offp: assert property (p_offp) else $error("off delay state wrong");
    property p_stay; !i_enable && !o_output_on |=> !o_output_on; endproperty
    a_stay: assert property (p_stay) else $error("output on while disabled");
    property p_rise; $rose(o_output_on) |-> o_ramp_up && $past(i_enable); endproperty
    a_rise: assert property (p_rise) else $error("output on without rise");
endmodule
bind pmb_cmd_bank pmb_cmd_bank_checker chk (.*);
`default_nettype wire

// ### pmb_host_model.sv
// serial bus host model feeding the byte engine
`timescale 1ns/10ps
`default_nettype none
module pmb_host_model (
    // clock and answers
    input wire logic       i_ref_clk, i_ack, i_rd_valid,
    input wire logic [7:0] i_rd_byte,
    // requests
    output logic           o_start, o_stop, o_valid, o_rd_req,
    output logic [7:0]     o_byte
);
    int acks = 0;  // bytes accepted
    initial {o_start, o_stop, o_valid, o_rd_req, o_byte} = '0;
    // one-cycle request pulse; m is start, stop, byte valid, read request
    task automatic pls(input logic [3:0] m);
        @(posedge i_ref_clk) {o_start, o_stop, o_valid, o_rd_req} <= m;
        @(posedge i_ref_clk) {o_start, o_stop, o_valid, o_rd_req} <= 4'h0;
    endtask
    // one byte, then its answer
    task automatic put(input logic [7:0] b);
        o_byte <= b;
        pls(4'h2);
        o_byte <= ~b;  // idle data shows the inverse
        @(posedge i_ref_clk) acks += int'(i_ack);
    endtask
    // write: command, data low byte first, stop
    task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
        pls(4'h8);
        put(c);
        for (int i = 0; i < n; i++) put(d[8*i +: 8]);
        pls(4'h4);
        repeat (2) @(posedge i_ref_clk);
    endtask
    // read two bytes after a repeated start
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        pls(4'h8);
        put(c);
        pls(4'h8);
        for (int i = 0; i < 2; i++) begin
            pls(4'h1);
            repeat (2) @(posedge i_ref_clk);
            d[8*i +: 8] = i_rd_valid ? i_rd_byte : 8'hxx;
        end
        pls(4'h4);
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// testbench of the command bank with its host model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_enable = 1'b0;
    logic        st, sp, bv, rq, ack, nack, rv, on, ramp, offp;
    logic [7:0]  bt, rb;
    logic [15:0] pg, otf, d, strap = 16'h2000;
    logic [15:0] lim [11];  // limit and action outputs, indexed like cd
    int          bad_count = 0, num_checks = 0;
    logic [7:0]  cd [16] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
                             8'h58, 8'h59, 8'h5a, 8'h60, 8'h61, 8'h64, 8'h4f, 8'h20};
    logic [15:0] dv [16] = '{16'h0080, 16'heb70, 16'he4e0, 16'he490, 16'h0080, 16'hd3a0, 16'h0080, 16'hd34d,
                             16'hca30, 16'hca00, 16'h0000, 16'hca80, 16'hd280, 16'hca80, 16'hebe8, 16'h0013};
    always #25 i_ref_clk = ~i_ref_clk;
    pmb_host_model h (.i_ref_clk(i_ref_clk), .i_ack(ack), .i_rd_valid(rv), .i_rd_byte(rb), .o_start(st),
                      .o_stop(sp), .o_valid(bv), .o_rd_req(rq), .o_byte(bt));
    pmb_cmd_bank #(.TICK_CYCLES(4)) dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bus_start(st),
        .i_bus_stop(sp), .i_bus_byte_valid(bv), .i_bus_byte(bt), .i_bus_rd_req(rq), .o_bus_ack(ack),
        .o_bus_nack(nack), .o_bus_rd_valid(rv), .o_bus_rd_byte(rb), .i_vout_strap(strap),
        .i_enable(i_enable), .o_overtemp_fault_limit(otf), .o_overtemp_fault_action(lim[0][7:0]),
        .o_overtemp_warning_limit(lim[1]), .o_undertemp_warning_limit(lim[2]), .o_undertemp_fault_limit(lim[3]),
        .o_undertemp_fault_action(lim[4][7:0]), .o_input_overvolt_fault_limit(lim[5]),
        .o_input_overvolt_fault_action(lim[6][7:0]), .o_input_overvolt_warning_limit(lim[7]),
        .o_input_undervolt_warning_limit(lim[8]), .o_input_undervolt_fault_limit(lim[9]),
        .o_input_undervolt_fault_action(lim[10][7:0]), .o_power_good_threshold(pg),
        .o_output_on(on), .o_ramp_up(ramp), .o_off_pending(offp));
    // byte entries answer ff in the high byte
    function automatic logic [15:0] ex(input logic [7:0] c, input logic [15:0] v);
        return (c inside {8'h50, 8'h54, 8'h56, 8'h5a, 8'h20}) ? {8'hff, v[7:0]} : v;
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // waits up to n cycles for the sequencer outputs
    task automatic wt(input logic [2:0] v, input int n);
        for (int k = 0; k < n && {on, ramp, offp} !== v; k++) @(posedge i_ref_clk);
        chk(16'({on, ramp, offp}), 16'(v));
    endtask
    task automatic t_dflt;
        for (int i = 0; i < 16; i++) begin
            h.rd(cd[i], d);
            chk(d, ex(cd[i], dv[i]));
        end
        h.rd(8'h5e, d);
        chk(d, 16'h1ccc);
        chk(pg, 16'h1ccc);
        $display("t_dflt done");
    endtask
    // default words: 5 ms is 80 ticks, 10 ms is 160 ticks, 4 cycles a tick
    task automatic t_seq;
        i_enable <= 1'b1;
        repeat (300) @(posedge i_ref_clk);
        chk(16'({on, ramp, offp}), 16'h0);
        wt(3'b110, 60);
        repeat (600) @(posedge i_ref_clk);
        chk(16'({on, ramp, offp}), 16'h6);
        wt(3'b100, 80);
        i_enable <= 1'b0;
        wt(3'b101, 4);
        repeat (300) @(posedge i_ref_clk);
        chk(16'({on, ramp, offp}), 16'h5);
        wt(3'b000, 60);
        $display("t_seq done");
    endtask
    task automatic t_wr;
        for (int i = 0; i < 15; i++) begin
            h.wr(cd[i], cd[i] inside {8'h50, 8'h54, 8'h56, 8'h5a} ? 1 : 2, ~dv[i]);
            h.rd(cd[i], d);
            chk(d, ex(cd[i], ~dv[i]));
            if (i < 11) chk(ex(cd[i], lim[i]), ex(cd[i], ~dv[i]));
        end
        chk(lim[1], 16'h148f);
        chk(otf, 16'h1417);
        $display("t_wr done");
    endtask
    task automatic t_bad;
        int a;
        a = h.acks;
        h.wr(8'h50, 2, 16'h1234);
        h.wr(8'h5b, 1, 16'h0011);
        h.wr(8'h20, 1, 16'h0011);
        chk(16'(h.acks - a), 16'h3);
        h.rd(8'h50, d);
        chk(d, 16'hff7f);
        h.rd(8'h5b, d);
        chk(d, 16'hffff);
        h.rd(8'h20, d);
        chk(d, 16'hff13);
        $display("t_bad done");
    endtask
    // mid-run reset with a new strap: defaults and the strapped threshold return
    task automatic t_rst;
        strap     <= 16'h1000;
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        chk(pg, 16'h0e66);
        h.rd(8'h50, d);
        chk(d, 16'hff80);
        $display("t_rst done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        t_dflt;
        t_seq;
        t_wr;
        t_bad;
        t_rst;
        close_out;
    end
    // watchdog
    initial begin
        #1000000;
        bad_count++;
        close_out;
    end
endmodule
`default_nettype wire
